// File: tla_pkg.sv
/*
 package for the temperature limit and alert block: register layout, reset values, timing constants,
 carrier structs. assumes nothing of its surroundings.
*/
package tla_pkg;
   // pointer codes select which register a read or write reaches
   localparam logic [1:0] PTR_TEMP   = 2'h0;
   localparam logic [1:0] PTR_CONFIG = 2'h1;
   localparam logic [1:0] PTR_LOWER  = 2'h2;
   localparam logic [1:0] PTR_UPPER  = 2'h3;
   localparam logic [1:0] PTR_RESET  = 2'h0;

   // configuration field positions (16-bit word, first byte in bits 15:8)
   localparam int CFG_SINGLE = 15;
   localparam int CFG_RES_HI = 14;
   localparam int CFG_RES_LO = 13;
   localparam int CFG_FLT_HI = 12;
   localparam int CFG_FLT_LO = 11;
   localparam int CFG_POL    = 10;
   localparam int CFG_TSEL   = 9;
   localparam int CFG_PDOWN  = 8;
   localparam int CFG_RATE_HI = 7;
   localparam int CFG_RATE_LO = 6;
   localparam int CFG_ALSTAT = 5;
   localparam int CFG_WIDE   = 4;

   localparam logic [1:0] RES_RESET   = 2'h3;
   localparam logic [1:0] RATE_RESET  = 2'h2;
   localparam logic [1:0] FAULT_RESET = 2'h0;

   // limit codes: 80 C and 75 C at 0.0625 C per lsb, left-justified in 16 bits
   localparam logic [15:0] UPPER_RESET_N = 16'h5000;
   localparam logic [15:0] LOWER_RESET_N = 16'h4B00;
   // same temperatures in the wide layout
   localparam logic [15:0] UPPER_RESET_W = 16'h2800;
   localparam logic [15:0] LOWER_RESET_W = 16'h2580;

   // conversion periods per rate code, and a single conversion time
   localparam int CLK_HZ         = 100_000_000;
   localparam int PERIOD_MS_0    = 4000;
   localparam int PERIOD_MS_1    = 1000;
   localparam int PERIOD_MS_2    = 250;
   localparam int PERIOD_MS_3    = 125;
   localparam int CONV_TIME_MS   = 26;
   localparam int PERIOD_CYC_0   = PERIOD_MS_0 * (CLK_HZ / 1000);
   localparam int PERIOD_CYC_1   = PERIOD_MS_1 * (CLK_HZ / 1000);
   localparam int PERIOD_CYC_2   = PERIOD_MS_2 * (CLK_HZ / 1000);
   localparam int PERIOD_CYC_3   = PERIOD_MS_3 * (CLK_HZ / 1000);
   localparam int CONV_CYC       = CONV_TIME_MS * (CLK_HZ / 1000);

   typedef struct packed {
      logic        single;
      logic [1:0]  fault;
      logic        alert_polarity_bit;
      logic        tsel;
      logic        pdown;
      logic [1:0]  rate;
      logic        wide;
   } tla_cfg_t;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [1:0]  ptr;
      logic [15:0] wdata;
   } tla_req_t;
endpackage : tla_pkg

// File: tla_fault_queue.sv
/*
 fault queue: counts uninterrupted runs of a fault condition and reports when the run meets the
 programmed length. assumes one pulse of i_sample per finished conversion.
*/
`timescale 1ns/1ps
module tla_fault_queue (
   input  wire logic       i_mclk,
   input  wire logic       i_rst_n,
   input  wire logic       i_ce,
   input  wire logic       i_clear,
   input  wire logic       i_sample,
   input  wire logic       i_fault,
   input  wire logic [1:0] i_fault_code,
   output logic            o_met
);
   logic [2:0] run_q;

   function automatic logic [2:0] fault_need(input logic [1:0] code);
      case (code)
         2'h0:    fault_need = 3'h1;
         2'h1:    fault_need = 3'h2;
         2'h2:    fault_need = 3'h4;
         default: fault_need = 3'h6;
      endcase
   endfunction : fault_need

   // saturate at six so a long run never wraps back below the threshold
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         run_q <= 3'h0;
      end else if (i_ce) begin
         if (i_clear) begin
            run_q <= 3'h0;
         end else if (i_sample) begin
            if (!i_fault) begin
               run_q <= 3'h0;
            end else if (run_q != 3'h6) begin
               run_q <= run_q + 3'h1;
            end
         end
      end
   end

   assign o_met = i_sample && i_fault && ((run_q + 3'h1) >= fault_need(i_fault_code));
endmodule : tla_fault_queue

// File: tla_alert_core.sv
/*
 configuration, limit registers and alert logic of a digital temperature sensor. the serial interface
 in front decodes the pointer byte and presents whole 16-bit register accesses as one-cycle strobes;
 the converter front end delivers a left-justified result on i_conv_done.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - resolution bits are read-only and read 11, meaning 12-bit results.
// - writing single-conversion 1 while powered down runs one conversion, then powers down.
// - single-conversion bit reads 0 while the triggered conversion runs.
// - wide-format bit clear: 12-bit format; set: 13-bit format for result and limits.
// - alert status bit is read-only and shows comparator status in either mode.
// - status reads 1, goes 0 after upper limit faults, back 1 after lower faults.
// - polarity bit set inverts the alert status bit read value.
// - rate field selects 0.25, 1, 4 or 8 conversions per second.
// - rate resets to the 4 Hz code.
// - each finished result is compared with both limits, driving the alert.
// - comparator mode: assert on upper faults, hold until lower-limit faults.
// - interrupt mode: assert on upper faults, hold until cleared.
// - interrupt mode: any register read or alert response answer clears alert.
// - interrupt mode: entering power-down clears alert.
// - after a clear, interrupt waits for the opposite limit; alternation continues.
// - general-call reset clears alert, resets registers, selects comparator mode.
// - limits transfer most significant byte first, then least significant byte.
// - reset limits are the codes for 80 C upper and 75 C lower.
// - limits use result layout, left-justified, unused low bits read zero.
// - fault count codes 00..11 require 1, 2, 4 or 6 consecutive faults.
// - alert output is active low with polarity 0, active high with polarity 1.
// - single-conversion bit reads 1 once the triggered conversion has completed.
// - power-down set finishes current conversion first; clear means continuous conversion.
module tla_alert_core #(
   parameter int unsigned PERIOD_CYC_0 = tla_pkg::PERIOD_CYC_0,
   parameter int unsigned PERIOD_CYC_1 = tla_pkg::PERIOD_CYC_1,
   parameter int unsigned PERIOD_CYC_2 = tla_pkg::PERIOD_CYC_2,
   parameter int unsigned PERIOD_CYC_3 = tla_pkg::PERIOD_CYC_3,
   parameter int unsigned CONV_CYC     = tla_pkg::CONV_CYC
) (
   input  wire logic             i_mclk,
   input  wire logic             i_rst_n,
   input  wire logic             i_ce,
   input  wire tla_pkg::tla_req_t i_req,
   input  wire logic             i_gc_reset,
   input  wire logic             i_ara_ack,
   input  wire logic             i_conv_done,
   input  wire logic [15:0]      i_conv_result,
   output logic [15:0]           o_rdata,
   output logic                  o_conv_start,
   output logic                  o_converting,
   output logic                  o_alert_level,
   output logic                  o_alert_pending
);
   typedef enum logic [1:0] {TLA_IDLE, TLA_CONV, TLA_WAIT} tla_conv_st_t;

   tla_conv_st_t      st_q;
   tla_pkg::tla_cfg_t cfg_q;
   logic [15:0]       temp_q;
   logic [15:0]       upper_q;
   logic [15:0]       lower_q;
   logic [15:0]       rdata_q;
   logic [31:0]       tmr_q;
   logic              one_shot_q;
   logic              shot_done_q;
   logic              comp_q;
   logic              intr_q;
   logic              intr_arm_hi_q;
   logic              start_q;
   logic              hi_met;
   logic              lo_met;
   logic              done;
   logic              fault_hi;
   logic              fault_lo;
   logic              clr_queue;
   logic              cfg_wr;
   logic              intr_clear;
   logic              sd_enter;

   // align a result into the active layout so signed compares stay exact
   function automatic logic signed [13:0] tla_value(input logic [15:0] word, input logic wide);
      if (wide) begin
         tla_value = $signed({word[15], word[15:3]});
      end else begin
         tla_value = $signed({{2{word[15]}}, word[15:4]});
      end
   endfunction : tla_value

   function automatic logic [15:0] tla_mask(input logic [15:0] word, input logic wide);
      tla_mask = wide ? {word[15:3], 3'h0} : {word[15:4], 4'h0};
   endfunction : tla_mask

   function automatic logic [31:0] tla_period(input logic [1:0] code);
      case (code)
         2'h0:    tla_period = PERIOD_CYC_0;
         2'h1:    tla_period = PERIOD_CYC_1;
         2'h2:    tla_period = PERIOD_CYC_2;
         default: tla_period = PERIOD_CYC_3;
      endcase
   endfunction : tla_period

   assign cfg_wr   = i_req.wr && (i_req.ptr == tla_pkg::PTR_CONFIG);
   assign done     = i_conv_done && (st_q == TLA_CONV);
   assign fault_hi = tla_value(i_conv_result, cfg_q.wide) >= tla_value(upper_q, cfg_q.wide);
   assign fault_lo = tla_value(i_conv_result, cfg_q.wide) <  tla_value(lower_q, cfg_q.wide);
   assign clr_queue = i_gc_reset;
   // power-down takes effect at the end of a running conversion or at once while waiting, which is also where the alert is cleared
   assign sd_enter = (done && cfg_q.pdown && !one_shot_q) || ((st_q == TLA_WAIT) && cfg_q.pdown);
   assign intr_clear = i_req.rd || i_ara_ack || sd_enter || (done && one_shot_q);

   // both queues sample every finished conversion, whatever the comparator status
   tla_fault_queue u_queue_hi (
      .i_mclk       (i_mclk),
      .i_rst_n      (i_rst_n),
      .i_ce         (i_ce),
      .i_clear      (clr_queue),
      .i_sample     (done),
      .i_fault      (fault_hi),
      .i_fault_code (cfg_q.fault),
      .o_met        (hi_met)
   );

   tla_fault_queue u_queue_lo (
      .i_mclk       (i_mclk),
      .i_rst_n      (i_rst_n),
      .i_ce         (i_ce),
      .i_clear      (clr_queue),
      .i_sample     (done),
      .i_fault      (fault_lo),
      .i_fault_code (cfg_q.fault),
      .o_met        (lo_met)
   );

   // configuration register; general-call reset returns every field to its reset value
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cfg_q.single <= 1'b0;
         cfg_q.fault  <= tla_pkg::FAULT_RESET;
         cfg_q.alert_polarity_bit    <= 1'b0;
         cfg_q.tsel   <= 1'b0;
         cfg_q.pdown  <= 1'b0;
         cfg_q.rate   <= tla_pkg::RATE_RESET;
         cfg_q.wide   <= 1'b0;
      end else if (i_ce) begin
         if (i_gc_reset) begin
            cfg_q.single <= 1'b0;
            cfg_q.fault  <= tla_pkg::FAULT_RESET;
            cfg_q.alert_polarity_bit    <= 1'b0;
            cfg_q.tsel   <= 1'b0;
            cfg_q.pdown  <= 1'b0;
            cfg_q.rate   <= tla_pkg::RATE_RESET;
            cfg_q.wide   <= 1'b0;
         end else if (cfg_wr) begin
            cfg_q.single <= 1'b0;
            cfg_q.fault  <= i_req.wdata[tla_pkg::CFG_FLT_HI:tla_pkg::CFG_FLT_LO];
            cfg_q.alert_polarity_bit    <= i_req.wdata[tla_pkg::CFG_POL];
            cfg_q.tsel   <= i_req.wdata[tla_pkg::CFG_TSEL];
            cfg_q.pdown  <= i_req.wdata[tla_pkg::CFG_PDOWN];
            cfg_q.rate   <= i_req.wdata[tla_pkg::CFG_RATE_HI:tla_pkg::CFG_RATE_LO];
            cfg_q.wide   <= i_req.wdata[tla_pkg::CFG_WIDE];
         end
      end
   end

   // limit registers, written as one word already assembled msb byte first
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         upper_q <= tla_pkg::UPPER_RESET_N;
         lower_q <= tla_pkg::LOWER_RESET_N;
      end else if (i_ce) begin
         if (i_gc_reset) begin
            upper_q <= tla_pkg::UPPER_RESET_N;
            lower_q <= tla_pkg::LOWER_RESET_N;
         end else if (i_req.wr && (i_req.ptr == tla_pkg::PTR_UPPER)) begin
            upper_q <= tla_mask(i_req.wdata, cfg_q.wide);
         end else if (i_req.wr && (i_req.ptr == tla_pkg::PTR_LOWER)) begin
            lower_q <= tla_mask(i_req.wdata, cfg_q.wide);
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         temp_q <= 16'h0000;
      end else if (i_ce) begin
         if (i_gc_reset) begin
            temp_q <= 16'h0000;
         end else if (done) begin
            temp_q <= cfg_q.wide ? {i_conv_result[15:3], 3'h1} : tla_mask(i_conv_result, 1'b0);
         end
      end
   end

   // conversion scheduler; timer counts the rest of the period after each conversion
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_q        <= TLA_WAIT;
         tmr_q       <= 32'h0000_0000;
         one_shot_q  <= 1'b0;
         shot_done_q <= 1'b0;
         start_q     <= 1'b0;
      end else if (i_ce) begin
         start_q <= 1'b0;
         if (i_gc_reset) begin
            st_q        <= TLA_WAIT;
            tmr_q       <= 32'h0000_0000;
            one_shot_q  <= 1'b0;
            shot_done_q <= 1'b0;
         end else begin
            case (st_q)
               TLA_IDLE: begin
                  if (cfg_wr && i_req.wdata[tla_pkg::CFG_SINGLE]) begin
                     st_q        <= TLA_CONV;
                     one_shot_q  <= 1'b1;
                     shot_done_q <= 1'b0;
                     start_q     <= 1'b1;
                  end else if (cfg_wr && !i_req.wdata[tla_pkg::CFG_PDOWN]) begin
                     st_q  <= TLA_WAIT;
                     tmr_q <= 32'h0000_0000;
                  end
               end
               TLA_CONV: begin
                  if (done) begin
                     tmr_q      <= tla_period(cfg_q.rate) - CONV_CYC;
                     one_shot_q <= 1'b0;
                     if (one_shot_q) begin
                        shot_done_q <= 1'b1;
                        st_q        <= TLA_IDLE;
                     end else if (cfg_q.pdown) begin
                        st_q <= TLA_IDLE;
                     end else begin
                        st_q <= TLA_WAIT;
                     end
                  end
               end
               TLA_WAIT: begin
                  if (cfg_q.pdown) begin
                     st_q <= TLA_IDLE;
                  end else if (tmr_q == 32'h0000_0000) begin
                     st_q    <= TLA_CONV;
                     start_q <= 1'b1;
                  end else begin
                     tmr_q <= tmr_q - 32'h0000_0001;
                  end
               end
               default: st_q <= TLA_IDLE;
            endcase
         end
      end
   end

   // comparator state: active after upper faults, idle again after lower faults
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         comp_q <= 1'b0;
      end else if (i_ce) begin
         if (i_gc_reset) begin
            comp_q <= 1'b0;
         end else if (!comp_q && hi_met) begin
            comp_q <= 1'b1;
         end else if (comp_q && lo_met) begin
            comp_q <= 1'b0;
         end
      end
   end

   // interrupt state: a new event outranks a clear in the same cycle
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         intr_q        <= 1'b0;
         intr_arm_hi_q <= 1'b1;
      end else if (i_ce) begin
         if (i_gc_reset || !cfg_q.tsel) begin
            intr_q        <= 1'b0;
            intr_arm_hi_q <= 1'b1;
         end else if (intr_arm_hi_q && hi_met && !intr_q) begin
            intr_q        <= 1'b1;
            intr_arm_hi_q <= 1'b0;
         end else if (!intr_arm_hi_q && lo_met && !intr_q) begin
            intr_q        <= 1'b1;
            intr_arm_hi_q <= 1'b1;
         end else if (intr_clear) begin
            intr_q <= 1'b0;
         end
      end
   end

   // read data is registered: sampled on the read strobe, held until the next one
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_q <= 16'h0000;
      end else if (i_ce) begin
         if (i_req.rd) begin
            case (i_req.ptr)
               tla_pkg::PTR_TEMP:   rdata_q <= temp_q;
               tla_pkg::PTR_CONFIG: rdata_q <= {
                     shot_done_q && !one_shot_q,
                     tla_pkg::RES_RESET,
                     cfg_q.fault, cfg_q.alert_polarity_bit, cfg_q.tsel, cfg_q.pdown,
                     cfg_q.rate,
                     !comp_q ^ cfg_q.alert_polarity_bit,
                     cfg_q.wide, 4'h0};
               tla_pkg::PTR_LOWER:  rdata_q <= tla_mask(lower_q, cfg_q.wide);
               default:             rdata_q <= tla_mask(upper_q, cfg_q.wide);
            endcase
         end
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_alert_level <= 1'b1;
      end else if (i_ce) begin
         // level driven on the pin: asserted value equals polarity bit
         o_alert_level <= ((cfg_q.tsel ? intr_q : comp_q) ~^ cfg_q.alert_polarity_bit);
      end
   end

   assign o_rdata         = rdata_q;
   assign o_conv_start    = start_q;
   assign o_converting    = (st_q == TLA_CONV);
   assign o_alert_pending = cfg_q.tsel && intr_q;
endmodule : tla_alert_core

// File: tla_alert_core_chk.sv
/*
 port-level assertions for tla_alert_core.
 assumes one clock with an asynchronous active-low reset; bound to every instance below.
*/
`timescale 1ns/1ps
module tla_alert_core_chk #(
   parameter int unsigned PERIOD_CYC_0 = tla_pkg::PERIOD_CYC_0,
   parameter int unsigned PERIOD_CYC_1 = tla_pkg::PERIOD_CYC_1,
   parameter int unsigned PERIOD_CYC_2 = tla_pkg::PERIOD_CYC_2,
   parameter int unsigned PERIOD_CYC_3 = tla_pkg::PERIOD_CYC_3,
   parameter int unsigned CONV_CYC     = tla_pkg::CONV_CYC
) (
   input wire logic              i_mclk,
   input wire logic              i_rst_n,
   input wire logic              i_ce,
   input wire tla_pkg::tla_req_t i_req,
   input wire logic              i_gc_reset,
   input wire logic              i_ara_ack,
   input wire logic              i_conv_done,
   input wire logic [15:0]       i_conv_result,
   input wire logic [15:0]       o_rdata,
   input wire logic              o_conv_start,
   input wire logic              o_converting,
   input wire logic              o_alert_level,
   input wire logic              o_alert_pending
);
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_n);
   sequence s_rd(p);
      i_ce && i_req.rd && i_req.ptr == p;
   endsequence
   // cycles with a finishing conversion are left out; a pending alert cannot be set again, so the clear would still win
   sequence s_clear;
      o_alert_pending && i_ce && !i_conv_done && (i_req.rd || i_ara_ack);
   endsequence
   sequence s_end;
      o_converting && i_conv_done && i_ce;
   endsequence
   property p_res;
      s_rd(tla_pkg::PTR_CONFIG) |=> o_rdata[14:13] == 2'h3 && o_rdata[3:0] == 4'h0;
   endproperty
   a_res: assert property (p_res) else $error("config read lost fixed resolution");
   property p_lim;
      i_ce && i_req.rd && i_req.ptr[1] |=> o_rdata[2:0] == 3'h0;
   endproperty
   a_lim: assert property (p_lim) else $error("limit read has low bits set");
   property p_temp;
      s_rd(tla_pkg::PTR_TEMP) |=> o_rdata[2:1] == 2'h0;
   endproperty
   a_temp: assert property (p_temp) else $error("result read has unused bits set");
   property p_busy;
      s_rd(tla_pkg::PTR_CONFIG) ##0 (o_converting && !i_conv_done) |=> !o_rdata[15];
   endproperty
   a_busy: assert property (p_busy) else $error("single bit set while converting");
   property p_clear;
      s_clear |=> !o_alert_pending;
   endproperty
   a_clear: assert property (p_clear) else $error("latched alert not cleared");
   property p_gc;
      i_gc_reset && i_ce |=> !o_alert_pending ##1 o_alert_level;
   endproperty
   a_gc: assert property (p_gc) else $error("general reset left alert active");
   property p_start;
      o_conv_start |-> o_converting ##1 !o_conv_start;
   endproperty
   a_start: assert property (p_start) else $error("conversion start malformed");
   property p_end;
      s_end |=> !o_converting;
   endproperty
   a_end: assert property (p_end) else $error("conversion did not end on done");
endmodule : tla_alert_core_chk

bind tla_alert_core tla_alert_core_chk #(.PERIOD_CYC_0(PERIOD_CYC_0), .PERIOD_CYC_1(PERIOD_CYC_1),
   .PERIOD_CYC_2(PERIOD_CYC_2), .PERIOD_CYC_3(PERIOD_CYC_3), .CONV_CYC(CONV_CYC)) i_chk (
   .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_req(i_req), .i_gc_reset(i_gc_reset),
   .i_ara_ack(i_ara_ack), .i_conv_done(i_conv_done), .i_conv_result(i_conv_result),
   .o_rdata(o_rdata), .o_conv_start(o_conv_start), .o_converting(o_converting),
   .o_alert_level(o_alert_level), .o_alert_pending(o_alert_pending));

// File: tla_host_model.sv
/*
 host stand-in: turns register calls into one-cycle word requests and returns the read data.
 assumes the serial layer has already paired the bytes of each word.
*/
`timescale 1ns/1ps
module tla_host_model (
   input  wire logic         i_mclk,
   input  wire logic [15:0]  i_rdata,
   output tla_pkg::tla_req_t o_req
);
   initial o_req = '0;
   // released pointer and data show the inverse and strobes drop to 0, so a stale value can never pass for a fresh one
   task automatic access(input logic w, input logic [1:0] p, input logic [15:0] d, output logic [15:0] q);
      @(posedge i_mclk);
      #1;
      o_req = '{wr: w, rd: !w, ptr: p, wdata: d};
      @(posedge i_mclk);
      #1;
      o_req = '{wr: 1'b0, rd: 1'b0, ptr: ~p, wdata: ~d};
      q = i_rdata;
   endtask : access
endmodule : tla_host_model

// File: tla_alert_core_bench.sv
/*
 self-checking bench for tla_alert_core with shortened conversion timing.
 assumes tla_host_model issues the register requests; a small converter stand-in lives here.
*/
`timescale 1ns/1ps
module tla_alert_core_bench;
   localparam logic [1:0]  PT   = tla_pkg::PTR_TEMP;
   localparam logic [1:0]  PC   = tla_pkg::PTR_CONFIG;
   localparam logic [1:0]  PL   = tla_pkg::PTR_LOWER;
   localparam logic [1:0]  PU   = tla_pkg::PTR_UPPER;
   localparam int          CONV = 5;
   localparam logic [15:0] HOT  = 16'h5000; // equal to the upper limit
   localparam logic [15:0] COLD = 16'h4AF0; // one step below the lower limit
   logic              i_mclk, i_rst_n, i_ce, i_gc_reset, i_ara_ack;
   logic              i_conv_done = 1'b0;
   logic [15:0]       i_conv_result, o_rdata, rd, base;
   logic              o_conv_start, o_converting, o_alert_level, o_alert_pending;
   tla_pkg::tla_req_t i_req;
   int                miscompares = 0, n_compared = 0, cyc = 0, cc = 0, n_done = 0, n_start = 0;
   int                last = 0, gap = 0, ns, k;
   int                periods[4] = '{40, 30, 20, 10};
   int                nflt[4] = '{1, 2, 4, 6};

   tla_alert_core #(.PERIOD_CYC_0(40), .PERIOD_CYC_1(30), .PERIOD_CYC_2(20), .PERIOD_CYC_3(10),
      .CONV_CYC(CONV)) i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_req(i_req),
      .i_gc_reset(i_gc_reset), .i_ara_ack(i_ara_ack), .i_conv_done(i_conv_done),
      .i_conv_result(i_conv_result), .o_rdata(o_rdata), .o_conv_start(o_conv_start),
      .o_converting(o_converting), .o_alert_level(o_alert_level), .o_alert_pending(o_alert_pending));
   tla_host_model i_host (.i_mclk(i_mclk), .i_rdata(o_rdata), .o_req(i_req));

   initial begin
      i_mclk = 1'b0;
      forever #5 i_mclk = ~i_mclk;
   end

   // converter stand-in: answers each start after CONV cycles; also the hang guard
   always @(posedge i_mclk) begin
      #1;
      cyc++;
      i_conv_done = 1'b0;
      if (o_conv_start) begin
         cc = CONV;
         n_start++;
         gap = cyc - last;
         last = cyc;
      end else if (cc > 0) begin
         cc--;
         if (cc == 0) begin
            i_conv_done = 1'b1;
            n_done++;
         end
      end
      if (cyc == 5000) begin
         miscompares++;
         wrap_up();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [1:0] p, input logic [15:0] d);
      i_host.access(1'b1, p, d, rd);
   endtask : wr
   task automatic rdc(input logic [1:0] p, input logic [15:0] exp, input logic [15:0] m = 16'hFFFF);
      i_host.access(1'b0, p, 16'h0000, rd);
      check(rd & m, exp);
   endtask : rdc
   // returns a few cycles after the n-th further conversion, once the alert outputs settled
   task automatic wait_done(input int n);
      int t;
      t = n_done + n;
      wait (n_done >= t);
      repeat (3) @(posedge i_mclk);
      #1;
   endtask : wait_done
   task automatic pulse(ref logic s);
      @(posedge i_mclk);
      #1;
      s = 1'b1;
      @(posedge i_mclk);
      #1;
      s = 1'b0;
   endtask : pulse
   function automatic logic [15:0] mk(input logic [1:0] f, input logic alert_polarity_bit, input logic ts,
                                      input logic pd, input logic [1:0] r, input logic w);
      return {3'h0, f, alert_polarity_bit, ts, pd, r, 1'h0, w, 4'h0};
   endfunction : mk
   function automatic logic [15:0] xc(input logic [15:0] w, input logic al);
      return w | 16'h6000 | {10'h000, al, 5'h00};
   endfunction : xc
   task automatic wrap_up;
      $display("comparisons %0d, miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : wrap_up

   initial begin
      i_rst_n = 1'b0;
      i_ce = 1'b1;
      i_gc_reset = 1'b0;
      i_ara_ack = 1'b0;
      i_conv_result = COLD;
      repeat (3) @(posedge i_mclk);
      #1;
      i_rst_n = 1'b1;
      base = xc(mk(2'h0, 1'b0, 1'b0, 1'b0, tla_pkg::RATE_RESET, 1'b0), 1'b1);
      rdc(PC, base);
      rdc(PU, tla_pkg::UPPER_RESET_N);
      rdc(PL, tla_pkg::LOWER_RESET_N);
      wr(PC, 16'hE02F);
      rdc(PC, xc(16'h0000, 1'b1));
      wr(PU, 16'h50FF);
      rdc(PU, 16'h50F0);
      wr(PC, mk(2'h0, 1'b0, 1'b0, 1'b0, 2'h2, 1'b1));
      wr(PL, 16'h4BFF);
      rdc(PL, 16'h4BF8);
      wr(PU, HOT);
      wr(PL, 16'h4B00);
      for (k = 0; k < 4; k++) begin
         wr(PC, mk(2'h0, 1'b0, 1'b0, 1'b0, k[1:0], 1'b0));
         ns = n_start + 2;
         wait (n_start >= ns);
         check(16'(gap >= periods[k] - 3 && gap <= periods[k] + 3), 16'h0001);
      end
      for (k = 0; k < 4; k++) begin
         wr(PC, mk(k[1:0], 1'b0, 1'b0, 1'b0, 2'h2, 1'b0));
         wait_done(1);
         i_conv_result = HOT;
         wait_done(nflt[k] - 1);
         check(16'(o_alert_level), 16'h0001);
         wait_done(1);
         check(16'(o_alert_level), 16'h0000);
         rdc(PC, xc(mk(k[1:0], 1'b0, 1'b0, 1'b0, 2'h2, 1'b0), 1'b0));
         i_conv_result = COLD;
         wait_done(nflt[k] - 1);
         check(16'(o_alert_level), 16'h0000);
         wait_done(1);
         check(16'(o_alert_level), 16'h0001);
      end
      wr(PC, mk(2'h0, 1'b1, 1'b0, 1'b0, 2'h2, 1'b0));
      i_conv_result = HOT;
      wait_done(1);
      check(16'(o_alert_level), 16'h0001);
      rdc(PC, xc(mk(2'h0, 1'b1, 1'b0, 1'b0, 2'h2, 1'b0), 1'b1));
      i_conv_result = COLD;
      wait_done(1);
      check(16'(o_alert_level), 16'h0000);
      wr(PC, mk(2'h0, 1'b0, 1'b1, 1'b0, 2'h2, 1'b0));
      i_conv_result = HOT;
      wait_done(1);
      check(16'(o_alert_pending), 16'h0001);
      rdc(PT, HOT);
      check(16'(o_alert_pending), 16'h0000);
      wait_done(1);
      check(16'(o_alert_pending), 16'h0000);
      i_conv_result = COLD;
      wait_done(1);
      check(16'(o_alert_pending), 16'h0001);
      pulse(i_ara_ack);
      check(16'(o_alert_pending), 16'h0000);
      i_conv_result = HOT;
      wait_done(1);
      check(16'(o_alert_pending), 16'h0001);
      // power down while a conversion runs, so it must finish first
      wait (o_converting === 1'b1);
      wr(PC, mk(2'h0, 1'b0, 1'b1, 1'b1, 2'h2, 1'b0));
      wait_done(1);
      check(16'(o_alert_pending), 16'h0000);
      ns = n_start;
      repeat (60) @(posedge i_mclk);
      check(16'(n_start - ns), 16'h0000);
      wr(PC, mk(2'h0, 1'b0, 1'b1, 1'b1, 2'h2, 1'b0) | 16'h8000);
      check(16'(o_converting), 16'h0001);
      rdc(PC, 16'h0000, 16'h8000);
      wait_done(1);
      rdc(PC, 16'h8000, 16'h8000);
      ns = n_start;
      repeat (60) @(posedge i_mclk);
      check(16'(n_start - ns), 16'h0000);
      wr(PC, mk(2'h3, 1'b1, 1'b1, 1'b1, 2'h3, 1'b1));
      wr(PU, 16'h6000);
      i_conv_result = COLD;
      pulse(i_gc_reset);
      check(16'(o_alert_pending), 16'h0000);
      rdc(PC, base);
      rdc(PU, tla_pkg::UPPER_RESET_N);
      check(16'(o_alert_level), 16'h0001);
      // clock enable low: a read must not reach the read data register
      i_ce = 1'b0;
      rdc(PC, tla_pkg::UPPER_RESET_N);
      i_ce = 1'b1;
      wrap_up();
   end
endmodule : tla_alert_core_bench
